// file: hdl/uer_pkg.sv
// shared constants and types of the usb endpoint mode responder
package uer_pkg;

  // register offsets in processor i/o space
  localparam logic [7:0] ADDR_EP1_MODE  = 8'h45;
  localparam logic [7:0] ADDR_EP2_MODE  = 8'h46;
  localparam logic [7:0] ADDR_CTRL_BUF  = 8'h50;
  localparam logic [7:0] ADDR_EP1_BUF   = 8'h58;
  localparam logic [7:0] ADDR_EP2_BUF   = 8'h60;
  localparam logic [7:0] ADDR_BUF_LAST  = 8'h67;

  // endpoint buffer geometry
  localparam int          BUF_BYTES     = 8;
  localparam int          NUM_EP        = 3;

  // mode register field positions and reset value
  localparam int          STALL_BIT     = 7;
  localparam int          ACKD_BIT      = 4;
  localparam logic [7:0]  MODE_RST      = 8'h00;

  // four-bit endpoint mode codes
  localparam logic [3:0]  M_DISABLE     = 4'h0;
  localparam logic [3:0]  M_NAK_IN_OUT  = 4'h1;
  localparam logic [3:0]  M_STATUS_OUT  = 4'h2;
  localparam logic [3:0]  M_STALL_IO    = 4'h3;
  localparam logic [3:0]  M_STATUS_IN   = 4'h6;
  localparam logic [3:0]  M_ACK_OUT_SIN = 4'hb;
  localparam logic [3:0]  M_ACK_IN_SOUT = 4'hf;
  localparam logic [3:0]  M_NAK_OUT     = 4'h8;
  localparam logic [3:0]  M_ACK_OUT     = 4'h9;
  localparam logic [3:0]  M_NAK_IN      = 4'hc;
  localparam logic [3:0]  M_ACK_IN      = 4'hd;

  // packet length limits, counted with the two crc bytes
  localparam logic [3:0]  LEN_MAX       = 4'ha;
  localparam logic [3:0]  LEN_ZERO_DATA = 4'h2;

  // token kinds from the serial interface engine
  typedef enum logic [1:0] {
    UER_TOK_SETUP,
    UER_TOK_IN,
    UER_TOK_OUT,
    UER_TOK_NONE
  } uer_tok_t;

  // answers given to the host
  typedef enum logic [2:0] {
    UER_R_IGNORE,
    UER_R_ACK,
    UER_R_NAK,
    UER_R_STALL,
    UER_R_TX
  } uer_resp_t;

endpackage

// file: hdl/uer_decide.sv
// combinational answer decision for one token against one endpoint mode
`timescale 1ns/1ps
module uer_decide (
  input  wire logic             is_ctrl,
  input  wire logic [3:0]       mode,
  input  wire logic             stall,
  input  uer_pkg::uer_tok_t     tok,
  input  wire logic [3:0]       pkt_len,
  input  wire logic             pkt_ok,
  input  wire logic             toggle,
  input  wire logic [3:0]       count,
  output uer_pkg::uer_resp_t    resp,
  output logic      [3:0]       tx_len
);

  logic out_ok;
  logic status_good;

  // data phases longer than the limit or with bad crc are dropped
  assign out_ok      = pkt_ok && (pkt_len <= uer_pkg::LEN_MAX);
  // zero data bytes and data toggle 1
  assign status_good = (pkt_len == uer_pkg::LEN_ZERO_DATA) && toggle;

  // mode table lookup
  always_comb begin
    resp   = uer_pkg::UER_R_IGNORE;
    tx_len = 4'h0;
    if (is_ctrl) begin
      if (tok == uer_pkg::UER_TOK_SETUP && out_ok) begin
        case (mode)
          uer_pkg::M_NAK_IN_OUT, uer_pkg::M_STATUS_OUT, uer_pkg::M_STALL_IO,
          uer_pkg::M_STATUS_IN, uer_pkg::M_ACK_OUT_SIN, uer_pkg::M_ACK_IN_SOUT: begin
            resp = uer_pkg::UER_R_ACK;
          end
          default: resp = uer_pkg::UER_R_IGNORE;
        endcase
      end else if (tok == uer_pkg::UER_TOK_IN) begin
        case (mode)
          uer_pkg::M_NAK_IN_OUT:  resp = uer_pkg::UER_R_NAK;
          uer_pkg::M_STATUS_OUT:  resp = uer_pkg::UER_R_STALL;
          uer_pkg::M_STALL_IO:    resp = uer_pkg::UER_R_STALL;
          uer_pkg::M_STATUS_IN:   resp = uer_pkg::UER_R_TX;
          uer_pkg::M_ACK_OUT_SIN: resp = uer_pkg::UER_R_TX;
          uer_pkg::M_ACK_IN_SOUT: begin
            resp   = uer_pkg::UER_R_TX;
            tx_len = count;
          end
          default: resp = uer_pkg::UER_R_IGNORE;
        endcase
      end else if (tok == uer_pkg::UER_TOK_OUT && out_ok) begin
        case (mode)
          uer_pkg::M_NAK_IN_OUT:  resp = uer_pkg::UER_R_NAK;
          uer_pkg::M_STALL_IO:    resp = uer_pkg::UER_R_STALL;
          uer_pkg::M_STATUS_IN:   resp = uer_pkg::UER_R_STALL;
          uer_pkg::M_ACK_OUT_SIN: resp = uer_pkg::UER_R_ACK;
          uer_pkg::M_STATUS_OUT, uer_pkg::M_ACK_IN_SOUT: begin
            resp = status_good ? uer_pkg::UER_R_ACK : uer_pkg::UER_R_STALL;
          end
          default: resp = uer_pkg::UER_R_IGNORE;
        endcase
      end
    end else begin
      // data endpoints never answer setup
      if (tok == uer_pkg::UER_TOK_IN) begin
        case (mode)
          uer_pkg::M_NAK_IN: resp = uer_pkg::UER_R_NAK;
          uer_pkg::M_ACK_IN: begin
            resp   = stall ? uer_pkg::UER_R_STALL : uer_pkg::UER_R_TX;
            tx_len = stall ? 4'h0 : count;
          end
          default: resp = uer_pkg::UER_R_IGNORE;
        endcase
      end else if (tok == uer_pkg::UER_TOK_OUT && out_ok) begin
        case (mode)
          uer_pkg::M_NAK_OUT: resp = uer_pkg::UER_R_NAK;
          uer_pkg::M_ACK_OUT: resp = stall ? uer_pkg::UER_R_STALL : uer_pkg::UER_R_ACK;
          default:            resp = uer_pkg::UER_R_IGNORE;
        endcase
      end
    end
  end

endmodule // uer_decide

// file: hdl/uer_responder.sv
// usb endpoint mode responder: mode registers, endpoint buffers and token answers
`timescale 1ns/1ps
module uer_responder (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // processor i/o port
  input  wire logic [7:0]       io_addr,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata,
  // control endpoint mode and per-endpoint byte counts
  input  wire logic [3:0]       ctrl_ep_mode,
  input  wire logic [3:0]       ctrl_ep_count,
  input  wire logic [3:0]       data_ep1_count,
  input  wire logic [3:0]       data_ep2_count,
  // token and data phase summary from the serial interface engine
  input  wire logic             tok_valid,
  input  uer_pkg::uer_tok_t     tok_kind,
  input  wire logic [1:0]       tok_ep,
  input  wire logic [3:0]       pkt_len,
  input  wire logic             pkt_ok,
  input  wire logic             pkt_toggle,
  input  wire logic             host_ack,
  // received data bytes into the buffer
  input  wire logic             rx_we,
  input  wire logic [2:0]       rx_idx,
  input  wire logic [7:0]       rx_data,
  // transmit byte fetch
  input  wire logic [2:0]       tx_idx,
  output logic      [7:0]       tx_data,
  // answer to the token
  output logic                  resp_valid,
  output uer_pkg::uer_resp_t    resp_kind,
  output logic      [3:0]       resp_len,
  output logic      [7:0]       data_ep1_mode,
  output logic      [7:0]       data_ep2_mode
);

  localparam int IDXW = $clog2(uer_pkg::NUM_EP * uer_pkg::BUF_BYTES);

  ////////////////////////////////////////////////////////////////////////////////
  // answer decision

  logic [3:0]          sel_mode;
  logic                sel_stall;
  logic [3:0]          sel_count;
  uer_pkg::uer_resp_t  dec_resp;
  logic [3:0]          dec_len;
  logic                tok_hit;

  // pick the addressed endpoint
  always_comb begin
    sel_mode  = 4'h0;
    sel_stall = 1'b0;
    sel_count = 4'h0;
    case (tok_ep)
      2'd0: begin
        sel_mode  = ctrl_ep_mode;
        sel_count = ctrl_ep_count;
      end
      2'd1: begin
        sel_mode  = data_ep1_mode[3:0];
        sel_stall = data_ep1_mode[uer_pkg::STALL_BIT];
        sel_count = data_ep1_count;
      end
      2'd2: begin
        sel_mode  = data_ep2_mode[3:0];
        sel_stall = data_ep2_mode[uer_pkg::STALL_BIT];
        sel_count = data_ep2_count;
      end
      default: sel_mode = uer_pkg::M_DISABLE;
    endcase
  end

  assign tok_hit = tok_valid && (tok_ep != 2'd3);

  uer_decide u_decide (
    .is_ctrl (tok_ep == 2'd0),
    .mode    (sel_mode),
    .stall   (sel_stall),
    .tok     (tok_hit ? tok_kind : uer_pkg::UER_TOK_NONE),
    .pkt_len (pkt_len),
    .pkt_ok  (pkt_ok),
    .toggle  (pkt_toggle),
    .count   (sel_count),
    .resp    (dec_resp),
    .tx_len  (dec_len)
  );

  // registered answer, pulsed for one cycle per token to endpoints 0 to 2; endpoint 3 tokens give no pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_kind  <= uer_pkg::UER_R_IGNORE;
      resp_len   <= 4'h0;
    end else begin
      resp_valid <= tok_hit;
      resp_kind  <= dec_resp;
      resp_len   <= dec_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // engine mode updates

  logic       in_wait_reg;   // a counted in awaits the host handshake
  logic [1:0] in_ep_reg;
  logic       eng_wr1;
  logic       eng_wr2;
  logic [3:0] eng_mode;
  logic       eng_upd;       // the one shared update strobe

  // track data endpoint transmissions until the host acks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_wait_reg <= 1'b0;
      in_ep_reg   <= 2'd0;
    end else if (tok_hit && dec_resp == uer_pkg::UER_R_TX && tok_ep != 2'd0) begin
      in_wait_reg <= 1'b1;
      in_ep_reg   <= tok_ep;
    end else if (host_ack || tok_hit) begin
      in_wait_reg <= 1'b0;
    end
  end

  // engine writes: ack out moves 1001 to 1000, acked in moves 1101 to 1100
  always_comb begin
    eng_wr1  = 1'b0;
    eng_wr2  = 1'b0;
    eng_mode = 4'h0;
    if (in_wait_reg && host_ack) begin
      eng_mode = uer_pkg::M_NAK_IN;
      eng_wr1  = (in_ep_reg == 2'd1);
      eng_wr2  = (in_ep_reg == 2'd2);
    end else if (tok_hit && tok_kind == uer_pkg::UER_TOK_OUT && dec_resp == uer_pkg::UER_R_ACK
                 && tok_ep != 2'd0) begin
      eng_mode = uer_pkg::M_NAK_OUT;
      eng_wr1  = (tok_ep == 2'd1);
      eng_wr2  = (tok_ep == 2'd2);
    end
  end

  assign eng_upd = eng_wr1 || eng_wr2;

  ////////////////////////////////////////////////////////////////////////////////
  // data endpoint mode registers

  logic fw_wr1;
  logic fw_wr2;

  // firmware writes pass only when the shared strobe is idle
  assign fw_wr1 = io_wr && (io_addr == uer_pkg::ADDR_EP1_MODE) && !eng_upd;
  assign fw_wr2 = io_wr && (io_addr == uer_pkg::ADDR_EP2_MODE) && !eng_upd;

  // ep1 mode: engine mode write sets acked flag, firmware write clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_ep1_mode <= uer_pkg::MODE_RST;
    end else if (eng_wr1) begin
      data_ep1_mode[3:0]              <= eng_mode;
      data_ep1_mode[uer_pkg::ACKD_BIT] <= 1'b1;
    end else if (fw_wr1) begin
      data_ep1_mode                   <= io_wdata;
      data_ep1_mode[uer_pkg::ACKD_BIT] <= 1'b0;
    end
  end

  // ep2 mode, same behaviour
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_ep2_mode <= uer_pkg::MODE_RST;
    end else if (eng_wr2) begin
      data_ep2_mode[3:0]              <= eng_mode;
      data_ep2_mode[uer_pkg::ACKD_BIT] <= 1'b1;
    end else if (fw_wr2) begin
      data_ep2_mode                   <= io_wdata;
      data_ep2_mode[uer_pkg::ACKD_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // endpoint buffers

  logic [7:0]      buf_mem [uer_pkg::NUM_EP * uer_pkg::BUF_BYTES];
  logic            io_buf_hit;
  logic [IDXW-1:0] io_buf_idx;
  logic [IDXW-1:0] rx_buf_idx;
  logic [IDXW-1:0] tx_buf_idx;
  logic [7:0]      io_off;

  // i/o window 0x50..0x67 holds all three buffers back to back
  assign io_off     = io_addr - uer_pkg::ADDR_CTRL_BUF;
  assign io_buf_hit = (io_addr >= uer_pkg::ADDR_CTRL_BUF) && (io_addr <= uer_pkg::ADDR_BUF_LAST);
  assign io_buf_idx = io_off[IDXW-1:0];
  assign rx_buf_idx = IDXW'({tok_ep, rx_idx});
  assign tx_buf_idx = IDXW'({in_ep_reg, tx_idx});

  // no reset on the storage; the engine wins a same-cycle clash
  always_ff @(posedge clk) begin
    if (rx_we && tok_ep != 2'd3) begin
      buf_mem[rx_buf_idx] <= rx_data;
    end else if (io_wr && io_buf_hit) begin
      buf_mem[io_buf_idx] <= io_wdata;
    end
  end

  // transmit byte for the endpoint being served
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_data <= 8'h00;
    end else begin
      tx_data <= buf_mem[(tok_hit && tok_kind == uer_pkg::UER_TOK_IN) ? IDXW'({tok_ep, tx_idx}) : tx_buf_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // i/o read path

  // registered read data, unmapped addresses read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == uer_pkg::ADDR_EP1_MODE) begin
        io_rdata <= data_ep1_mode;
      end else if (io_addr == uer_pkg::ADDR_EP2_MODE) begin
        io_rdata <= data_ep2_mode;
      end else if (io_buf_hit) begin
        io_rdata <= buf_mem[io_buf_idx];
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

endmodule // uer_responder

// file: tb/uer_chk_assertions.sv
// port checks of the endpoint mode responder
`timescale 1ns/1ps
module uer_chk (
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic [7:0]    io_addr,
  input wire logic          io_wr,
  input wire logic [3:0]    ctrl_ep_mode,
  input wire logic [3:0]    ctrl_ep_count,
  input wire logic          tok_valid,
  input uer_pkg::uer_tok_t  tok_kind,
  input wire logic [1:0]    tok_ep,
  input wire logic [3:0]    pkt_len,
  input wire logic          pkt_ok,
  input wire logic          pkt_toggle,
  input wire logic          resp_valid,
  input uer_pkg::uer_resp_t resp_kind,
  input wire logic [3:0]    resp_len,
  input wire logic [7:0]    data_ep1_mode,
  input wire logic [7:0]    data_ep2_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic c0, cin, cout, good, o1;
  // tokens sorted by endpoint and kind
  assign c0   = tok_valid && tok_ep == 2'h0;
  assign cin  = c0 && tok_kind == uer_pkg::UER_TOK_IN;
  assign good = pkt_ok && pkt_len <= 4'ha;
  assign cout = c0 && tok_kind == uer_pkg::UER_TOK_OUT && good;
  assign o1   = tok_valid && tok_ep == 2'h1 && tok_kind == uer_pkg::UER_TOK_OUT && good;
  ////////////////////////////////////////////////////////////////
  chk_disabled_ignore: assert property (
    c0 && ctrl_ep_mode == 4'h0 |=> resp_valid && resp_kind == uer_pkg::UER_R_IGNORE)
    else $error("disabled endpoint answered");
  chk_ctrl_nak: assert property (
    cin && ctrl_ep_mode == 4'h1 |=> resp_kind == uer_pkg::UER_R_NAK) else $error("no nak");
  chk_ctrl_stall: assert property (
    cin && ctrl_ep_mode == 4'h3 |=> resp_kind == uer_pkg::UER_R_STALL) else $error("no stall");
  chk_zero_tx: assert property (
    cin && ctrl_ep_mode == 4'h6 |=> resp_kind == uer_pkg::UER_R_TX && resp_len == 4'h0)
    else $error("zero byte answer wrong");
  chk_count_tx: assert property (
    cin && ctrl_ep_mode == 4'hf |=> resp_kind == uer_pkg::UER_R_TX && resp_len == $past(ctrl_ep_count))
    else $error("counted answer wrong");
  chk_status_good: assert property (
    cout && ctrl_ep_mode == 4'h2 && pkt_len == 4'h2 && pkt_toggle |=> resp_kind == uer_pkg::UER_R_ACK)
    else $error("good status not acked");
  chk_ep1_auto: assert property (
    o1 && data_ep1_mode[3:0] == 4'h9 && !data_ep1_mode[7]
    |=> resp_kind == uer_pkg::UER_R_ACK && data_ep1_mode[4:0] == 5'h18) else $error("ep1 no auto step");
  chk_fw_blocked: assert property (
    o1 && data_ep1_mode[3:0] == 4'h9 && !data_ep1_mode[7] && io_wr && io_addr == 8'h46
    |=> $stable(data_ep2_mode)) else $error("firmware write not blocked");
  // main scenarios reached
  cover property (o1 && data_ep1_mode[3:0] == 4'h9);
  cover property (cin && ctrl_ep_mode == 4'hf);
  cover property (resp_valid && resp_kind == uer_pkg::UER_R_TX);
endmodule // uer_chk

bind uer_responder uer_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
  .ctrl_ep_mode(ctrl_ep_mode), .ctrl_ep_count(ctrl_ep_count), .tok_valid(tok_valid),
  .tok_kind(tok_kind), .tok_ep(tok_ep), .pkt_len(pkt_len), .pkt_ok(pkt_ok),
  .pkt_toggle(pkt_toggle), .resp_valid(resp_valid), .resp_kind(resp_kind),
  .resp_len(resp_len), .data_ep1_mode(data_ep1_mode), .data_ep2_mode(data_ep2_mode)
);

// file: tb/uer_host.sv
// host controller model issuing tokens and handshakes
`timescale 1ns/1ps
module uer_host (
  input wire logic   clk,
  output logic       tok_valid,
  output uer_pkg::uer_tok_t tok_kind,
  output logic [1:0] tok_ep,
  output logic [3:0] pkt_len,
  output logic       pkt_ok,
  output logic       pkt_toggle,
  output logic       host_ack
);
  initial begin
    tok_valid = 1'b0;
    tok_kind = uer_pkg::UER_TOK_NONE;
    tok_ep = 2'h3;
    pkt_len = 4'h0;
    pkt_ok = 1'b0;
    pkt_toggle = 1'b0;
    host_ack = 1'b0;
  end
  // one token for one cycle; released kind then shows none, the other fields the inverse
  task automatic send(input uer_pkg::uer_tok_t k, input logic [1:0] e, input logic [3:0] n,
                      input logic ok, input logic tg);
    @(negedge clk);
    tok_valid = 1'b1;
    tok_kind = k;
    tok_ep = e;
    pkt_len = n;
    pkt_ok = ok;
    pkt_toggle = tg;
    @(negedge clk);
    tok_valid = 1'b0;
    tok_kind = uer_pkg::UER_TOK_NONE;
    tok_ep = ~e;
    pkt_len = ~n;
    pkt_ok = ~ok;
    pkt_toggle = ~tg;
  endtask
  // handshake after sent data, d idle cycles late
  task automatic ack(input int d);
    repeat (d + 1) @(negedge clk);
    host_ack = 1'b1;
    @(negedge clk);
    host_ack = 1'b0;
  endtask
endmodule // uer_host

// file: tb/tb.sv
// self-checking testbench of the endpoint mode responder
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, io_wr, io_rd, rx_we, tok_valid, pkt_ok, pkt_toggle, host_ack, resp_valid;
  logic [7:0] io_addr, io_wdata, io_rdata, rx_data, tx_data, data_ep1_mode, data_ep2_mode;
  logic [3:0] ctrl_ep_mode, ctrl_ep_count, data_ep1_count, data_ep2_count, pkt_len, resp_len;
  logic [2:0] rx_idx, tx_idx;
  logic [1:0] tok_ep;
  uer_pkg::uer_tok_t  tok_kind;
  uer_pkg::uer_resp_t resp_kind;
  int mismatches = 0;
  int n_tests = 0;
  uer_responder dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ctrl_ep_mode(ctrl_ep_mode), .ctrl_ep_count(ctrl_ep_count),
    .data_ep1_count(data_ep1_count), .data_ep2_count(data_ep2_count), .tok_valid(tok_valid),
    .tok_kind(tok_kind), .tok_ep(tok_ep), .pkt_len(pkt_len), .pkt_ok(pkt_ok), .pkt_toggle(pkt_toggle),
    .host_ack(host_ack), .rx_we(rx_we), .rx_idx(rx_idx), .rx_data(rx_data), .tx_idx(tx_idx),
    .tx_data(tx_data), .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_len(resp_len),
    .data_ep1_mode(data_ep1_mode), .data_ep2_mode(data_ep2_mode));
  uer_host host (.clk(clk), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep(tok_ep),
    .pkt_len(pkt_len), .pkt_ok(pkt_ok), .pkt_toggle(pkt_toggle), .host_ack(host_ack));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // firmware i/o cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkr(input string n, input uer_pkg::uer_resp_t e, input logic [3:0] l);
    n_tests++;
    if (resp_valid !== 1'b1 || resp_kind !== e || (e == uer_pkg::UER_R_TX && resp_len !== l)) begin
      mismatches++;
      $display("ERROR %s expected %0d/%h seen %0d/%h", n, e, l, resp_kind, resp_len);
    end
  endtask
  task automatic tok(input string n, input int k, input logic [1:0] e, input logic [3:0] len,
                     input logic tg, input uer_pkg::uer_resp_t x, input logic [3:0] l);
    host.send(uer_pkg::uer_tok_t'(k), e, len, 1'b1, tg);
    chkr(n, x, l);
  endtask
  function automatic uer_pkg::uer_resp_t c2r(input byte c);
    case (c)
      "A": return uer_pkg::UER_R_ACK;
      "N": return uer_pkg::UER_R_NAK;
      "S": return uer_pkg::UER_R_STALL;
      "T": return uer_pkg::UER_R_TX;
      default: return uer_pkg::UER_R_IGNORE;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] d;
    chk8("ep1 mode reset", uer_pkg::MODE_RST, data_ep1_mode);
    rd(8'h46, d);
    chk8("ep2 mode reset", uer_pkg::MODE_RST, d);
    wr(8'h45, 8'hff);
    rd(8'h45, d);
    chk8("ep1 mode rw", 8'hef, d);
    wr(8'h47, 8'h33);
    rd(8'h47, d);
    chk8("unmapped", 8'h00, d);
    $display("done regs");
  endtask
  task automatic t_bufs();
    logic [7:0] d;
    for (int a = 'h50; a < 'h68; a++) wr(8'(a), 8'(a) ^ 8'h5a);
    for (int a = 'h4f; a < 'h69; a++) begin
      rd(8'(a), d);
      chk8("buffer byte", (a < 'h50 || a > 'h67) ? 8'h00 : 8'(a) ^ 8'h5a, d);
    end
    $display("done buffers");
  endtask
  task automatic t_ctrl();
    logic [3:0] m [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'hb, 4'hf, 4'h4, 4'h5, 4'h7, 4'ha, 4'he, 4'h9, 4'hd};
    string s [14] = '{"III", "ANN", "ASA", "ASS", "ATS", "ATA", "ATA", "III", "III", "III", "III", "III",
                      "III", "III"};
    ctrl_ep_count = 4'h5;
    foreach (m[i]) begin
      ctrl_ep_mode = m[i];
      for (int k = 0; k < 3; k++) begin
        tok("ctrl", k, 2'h0, 4'h2, 1'b1, c2r(s[i][k]), m[i] == 4'hf ? 4'h5 : 4'h0);
      end
    end
    ctrl_ep_mode = 4'h2;
    tok("status toggle", 2, 2'h0, 4'h2, 1'b0, uer_pkg::UER_R_STALL, 4'h0);
    ctrl_ep_mode = 4'hf;
    tok("status length", 2, 2'h0, 4'h4, 1'b1, uer_pkg::UER_R_STALL, 4'h0);
    tok("long setup", 0, 2'h0, 4'hb, 1'b1, uer_pkg::UER_R_IGNORE, 4'h0);
    host.send(uer_pkg::UER_TOK_OUT, 2'h0, 4'h2, 1'b0, 1'b1);
    chkr("bad out", uer_pkg::UER_R_IGNORE, 4'h0);
    $display("done control");
  endtask
  task automatic t_data();
    logic [3:0] m [6] = '{4'h0, 4'h8, 4'hc, 4'h1, 4'h5, 4'hf};
    string s [6] = '{"III", "IIN", "INI", "III", "III", "III"};
    for (int e = 1; e < 3; e++) begin
      foreach (m[i]) begin
        wr(8'h44 + 8'(e), {4'h0, m[i]});
        for (int k = 0; k < 3; k++) begin
          tok("data", k, 2'(e), 4'h2, 1'b1, c2r(s[i][k]), 4'h0);
        end
      end
    end
    $display("done data");
  endtask
  task automatic t_ep1();
    logic [7:0] d;
    wr(8'h45, 8'h09);
    wr(8'h46, 8'h08);
    fork
      host.send(uer_pkg::UER_TOK_OUT, 2'h1, 4'h4, 1'b1, 1'b0);
      wr(8'h46, 8'h0c);
      begin
        @(negedge clk);
        rx_we = 1'b1;
        @(negedge clk);
        rx_we = 1'b0;
      end
    join
    chkr("ep1 out", uer_pkg::UER_R_ACK, 4'h0);
    chk8("ep1 mode", 8'h18, data_ep1_mode);
    chk8("ep2 blocked", 8'h08, data_ep2_mode);
    rd(8'h46, d);
    if (d !== 8'h0c) wr(8'h46, 8'h0c);
    chk8("ep2 rewrite", 8'h0c, data_ep2_mode);
    rd(8'h5b, d);
    chk8("ep1 rx byte", 8'h3c, d);
    wr(8'h45, 8'h89);
    tok("ep1 stall", 2, 2'h1, 4'h2, 1'b1, uer_pkg::UER_R_STALL, 4'h0);
    chk8("ep1 stall mode", 8'h89, data_ep1_mode);
    $display("done ep1");
  endtask
  task automatic t_ep2();
    data_ep2_count = 4'h3;
    tx_idx = 3'h1;
    wr(8'h46, 8'h0d);
    wr(8'h45, 8'h08);
    tok("ep2 in", 1, 2'h2, 4'h2, 1'b1, uer_pkg::UER_R_TX, 4'h3);
    chk8("ep2 tx byte", 8'h61 ^ 8'h5a, tx_data);
    fork
      host.ack(3);
      begin
        repeat (3) @(negedge clk);
        wr(8'h45, 8'h0c);
      end
    join
    chk8("ep2 acked", 8'h1c, data_ep2_mode);
    chk8("ep1 blocked", 8'h08, data_ep1_mode);
    wr(8'h46, 8'h8d);
    tok("ep2 stall", 1, 2'h2, 4'h2, 1'b1, uer_pkg::UER_R_STALL, 4'h0);
    $display("done ep2");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    {io_wr, io_rd, rx_we, io_addr, io_wdata} = '0;
    {ctrl_ep_mode, ctrl_ep_count, data_ep1_count, data_ep2_count, tx_idx} = '0;
    rx_idx = 3'h3;
    rx_data = 8'h3c;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_bufs();
    t_ctrl();
    t_data();
    t_ep1();
    t_ep2();
    give_verdict();
  end
  // tests need under four hundred cycles; cut a hang at twenty thousand
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule // tb
